/* csm_socket.sv */
`timescale 1ns/10ps
`default_nettype none
module csm_socket
	import csm_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [7:0]   reg_addr,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [31:0]  reg_wdata,
	output logic      [31:0]  reg_rdata,
	output logic              reg_rvalid,
	input  wire csm_pins_s    pins,
	input  wire logic         identify_busy,
	input  wire logic         identify_done,
	input  wire csm_card_id_s identify_result,
	input  wire logic         socket_power_on,
	input  wire logic         invalid_supply_request,
	input  wire logic         removal_data_loss,
	input  wire logic         socket_3v3_disable,
	output logic              status_change_interrupt
);

	// ==========================================================
	// Pin synchronisation
	csm_pins_s pins_sync;
	logic [CSM_PINS_W-1:0] pins_sync_bits;

	csm_sync #(
		.W         (CSM_PINS_W),
		.RESET_VAL (4'b1100)
	) u_sync (
		.clk      (clk),
		.rstn     (rstn),
		.async_in (pins),
		.sync_out (pins_sync_bits)
	);

	assign pins_sync = csm_pins_s'(pins_sync_bits);

	// ==========================================================
	// Register access decode
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr[7:2] == ofs[7:2]);
	endfunction : hit

	logic wr_event;
	logic wr_mask;
	logic wr_force;

	assign wr_event = reg_wr && hit(reg_addr, CSM_OFS_EVENT);
	assign wr_mask  = reg_wr && hit(reg_addr, CSM_OFS_MASK);
	assign wr_force = reg_wr && hit(reg_addr, CSM_OFS_FORCE);

	// ==========================================================
	// Mask register
	logic       power_cycle_irq_enable_q;
	logic [1:0] card_detect_irq_enable_q;
	logic       card_status_irq_enable_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_cycle_irq_enable_q <= CSM_MASK_RESET[CSM_EV_POWER];
			card_detect_irq_enable_q <= CSM_MASK_RESET[CSM_EV_CD2:CSM_EV_CD1];
			card_status_irq_enable_q <= CSM_MASK_RESET[CSM_EV_STATUS];
		end else if (wr_mask) begin
			power_cycle_irq_enable_q <= reg_wdata[CSM_EV_POWER];
			card_detect_irq_enable_q <= reg_wdata[CSM_EV_CD2:CSM_EV_CD1];
			card_status_irq_enable_q <= reg_wdata[CSM_EV_STATUS];
		end
	end

	// ==========================================================
	// Reported detect lines, frozen during identification
	logic [1:0] det_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			det_q <= CSM_DET_RESET;
		end else if (!identify_busy) begin
			det_q <= {pins_sync.detect_line_two_level,
			          pins_sync.detect_line_one_level};
		end
	end

	// ==========================================================
	// Live status and power history, reported detect history, for edge detection
	logic       status_prev_q;
	logic       powered_q;
	logic       powered_prev_q;
	logic [1:0] det_prev_q;
	logic [1:0] det_changed;
	logic       power_changed;

	// Idle level of the status line, so no false edge follows reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_prev_q <= 1'b0;
		end else begin
			status_prev_q <= pins_sync.status_line_level;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			powered_q      <= CSM_FLAG_RESET;
			powered_prev_q <= CSM_FLAG_RESET;
		end else begin
			powered_q      <= socket_power_on;
			powered_prev_q <= powered_q;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			det_prev_q <= CSM_DET_RESET;
		end else begin
			det_prev_q <= det_q;
		end
	end

	// Compared with the reported bits, so a frozen detect field raises no event
	assign det_changed   = det_q ^ det_prev_q;
	assign power_changed = powered_q ^ powered_prev_q;

	// ==========================================================
	// Card identity fields
	logic [3:0] card_volt_q;
	logic       unrecognized_card_q;
	logic       thirtytwo_bit_card_present_q;
	logic       sixteen_bit_card_present_q;

	// An unrecognized card leaves the last valid voltage and type in place
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			card_volt_q <= CSM_VOLT_RESET;
		end else if (wr_force) begin
			card_volt_q <= reg_wdata[CSM_PS_VOLT_HI:CSM_PS_VOLT_LO];
		end else if (identify_done && !identify_result.unrecognized_card) begin
			card_volt_q <= identify_result.volt;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			thirtytwo_bit_card_present_q <= CSM_FLAG_RESET;
			sixteen_bit_card_present_q   <= CSM_FLAG_RESET;
		end else if (wr_force) begin
			thirtytwo_bit_card_present_q <= reg_wdata[CSM_PS_CARD32];
			sixteen_bit_card_present_q   <= reg_wdata[CSM_PS_CARD16];
		end else if (identify_done && !identify_result.unrecognized_card) begin
			thirtytwo_bit_card_present_q <= identify_result.thirtytwo_bit_card_present;
			sixteen_bit_card_present_q   <= identify_result.sixteen_bit_card_present;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			unrecognized_card_q <= CSM_FLAG_RESET;
		end else if (wr_force) begin
			unrecognized_card_q <= reg_wdata[CSM_PS_UNRECOG];
		end else if (identify_done) begin
			unrecognized_card_q <= identify_result.unrecognized_card;
		end
	end

	// ==========================================================
	// Supply and data-loss flags
	logic force_bad_supply_q;
	logic removal_data_loss_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			force_bad_supply_q <= CSM_FLAG_RESET;
		end else if (wr_force) begin
			force_bad_supply_q <= reg_wdata[CSM_PS_BAD_SUPPLY];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			removal_data_loss_q <= CSM_FLAG_RESET;
		end else if (removal_data_loss) begin
			removal_data_loss_q <= 1'b1;
		end else if (wr_force) begin
			removal_data_loss_q <= reg_wdata[CSM_PS_DATA_LOSS];
		end else if (identify_done && !identify_result.unrecognized_card) begin
			removal_data_loss_q <= 1'b0;
		end
	end

	// ==========================================================
	// Socket event register
	logic [CSM_EV_W-1:0] event_q;
	logic [CSM_EV_W-1:0] event_set;
	logic [CSM_EV_W-1:0] event_clr;
	logic                status_rise;
	logic                status_fall;

	assign status_rise = pins_sync.status_line_level && !status_prev_q;
	assign status_fall = !pins_sync.status_line_level && status_prev_q;

	always_comb begin
		event_set                = '0;
		event_set[CSM_EV_STATUS] = thirtytwo_bit_card_present_q ? status_rise
		                           : (status_rise || status_fall);
		event_set[CSM_EV_CD1]    = det_changed[0];
		event_set[CSM_EV_CD2]    = det_changed[1];
		event_set[CSM_EV_POWER]  = power_changed;
		if (wr_force) begin
			event_set = event_set | reg_wdata[CSM_EV_W-1:0];
		end
	end

	assign event_clr = wr_event ? reg_wdata[CSM_EV_W-1:0] : '0;

	genvar gi;
	generate
		for (gi = 0; gi < CSM_EV_W; gi++) begin : g_event
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					event_q[gi] <= CSM_EVENT_RESET[gi];
				end else if (event_set[gi]) begin
					event_q[gi] <= 1'b1;
				end else if (event_clr[gi]) begin
					event_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Status change interrupt
	logic [CSM_EV_W-1:0] enable_vec;

	assign enable_vec = {power_cycle_irq_enable_q, card_detect_irq_enable_q,
	                     card_status_irq_enable_q};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_change_interrupt <= 1'b0;
		end else begin
			status_change_interrupt <= |(event_q & enable_vec);
		end
	end

	// ==========================================================
	// Read views
	logic [31:0] mask_view;
	logic [31:0] present_view;

	always_comb begin
		mask_view                           = '0;
		mask_view[CSM_EV_W-1:0]             = enable_vec;
	end

	always_comb begin
		present_view                        = '0;
		present_view[CSM_PS_FUT_Y_SOCK]     = 1'b0;
		present_view[CSM_PS_FUT_X_SOCK]     = 1'b0;
		present_view[CSM_PS_3V3_SOCK]       = !socket_3v3_disable;
		present_view[CSM_PS_5V0_SOCK]       = 1'b1;
		present_view[CSM_PS_VOLT_HI:CSM_PS_VOLT_LO] = card_volt_q;
		present_view[CSM_PS_BAD_SUPPLY]     = invalid_supply_request
		                                      || force_bad_supply_q;
		present_view[CSM_PS_DATA_LOSS]      = removal_data_loss_q;
		present_view[CSM_PS_UNRECOG]        = unrecognized_card_q;
		present_view[CSM_PS_IRQ_LINE]       = pins_sync.card_irq_line_level;
		present_view[CSM_PS_CARD32]         = thirtytwo_bit_card_present_q;
		present_view[CSM_PS_CARD16]         = sixteen_bit_card_present_q;
		present_view[CSM_PS_POWERED]        = powered_q;
		present_view[CSM_PS_DET2]           = det_q[1];
		present_view[CSM_PS_DET1]           = det_q[0];
		present_view[CSM_PS_STATUS_LINE]    = pins_sync.status_line_level;
	end

	// ==========================================================
	// Read data register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// Read data holds until the next read strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			if (reg_rd) begin
				if (hit(reg_addr, CSM_OFS_EVENT)) begin
					reg_rdata <= {28'h000_0000, event_q};
				end else if (hit(reg_addr, CSM_OFS_MASK)) begin
					reg_rdata <= mask_view;
				end else if (hit(reg_addr, CSM_OFS_PRESENT)) begin
					reg_rdata <= present_view;
				end else begin
					reg_rdata <= 32'h0000_0000;
				end
			end
		end
	end

endmodule : csm_socket
`default_nettype wire

/* csm_pkg.sv */
// What this block does
// - Event bits set whatever the mask holds; the mask only gates the interrupt.
// - Mask bit 3 enables power-cycle events onto the interrupt; reset value zero.
// - Mask bits 2-1 enable card-detect events; 00 at reset, 11 enables both.
// - Mask bit 0 enables status-line change events onto the interrupt; reset zero.
// - Mask bits 31-4 read zero and hold nothing written.
// - Card voltage and type fields change only when an interrogation of a recognized card completes, or at a forced write.
// - While a card is being identified, detect-line changes are not reported.
// - Present-state bits 31 and 30 always read zero.
// - Present-state bit 29 reads one unless the 3.3 V disable input is set.
// - Present-state bit 28 always reads one.
// - Present-state bits 27-14 read zero.
// - Bits 13-10 show card voltage support; force-event writes can set them.
// - Bit 9 shows an invalid supply request from software; zero normally.
// - Bit 8 flags possible data loss at card removal.
// - Bit 7 flags an unrecognized card, held until a valid card arrives.
// - Bit 6 shows the live card ready/interrupt line level.
// - Bits 5 and 4 flag card width, changed only at the next interrogation or a force-event write.
// - Bit 3 shows socket power, zero at reset, one when powered.
// - Bits 2 and 1 mirror the two detect lines; one means no card.
// - Bit 0 mirrors the live status-change line level.
// - Writing one clears an event bit; writing zero leaves it.
// - Status event on rising edge for 32-bit cards, both edges for 16-bit cards.
// - Force-event writes to voltage and type bits land in the present-state bits.
package csm_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] CSM_OFS_EVENT   = 8'h00;
	localparam logic [7:0] CSM_OFS_MASK    = 8'h04;
	localparam logic [7:0] CSM_OFS_PRESENT = 8'h08;
	localparam logic [7:0] CSM_OFS_FORCE   = 8'h0C;

	// ==========================================================
	// Event, mask and force low-nibble positions
	localparam int CSM_EV_STATUS = 0;
	localparam int CSM_EV_CD1    = 1;
	localparam int CSM_EV_CD2    = 2;
	localparam int CSM_EV_POWER  = 3;
	localparam int CSM_EV_W      = 4;

	localparam logic [3:0]  CSM_EVENT_RESET = 4'h0;
	localparam logic [3:0]  CSM_MASK_RESET  = 4'h0;

	// ==========================================================
	// Present-state field positions
	localparam int CSM_PS_FUT_Y_SOCK  = 31;
	localparam int CSM_PS_FUT_X_SOCK  = 30;
	localparam int CSM_PS_3V3_SOCK    = 29;
	localparam int CSM_PS_5V0_SOCK    = 28;
	localparam int CSM_PS_VOLT_HI     = 13;
	localparam int CSM_PS_VOLT_LO     = 10;
	localparam int CSM_PS_BAD_SUPPLY  = 9;
	localparam int CSM_PS_DATA_LOSS   = 8;
	localparam int CSM_PS_UNRECOG     = 7;
	localparam int CSM_PS_IRQ_LINE    = 6;
	localparam int CSM_PS_CARD32      = 5;
	localparam int CSM_PS_CARD16      = 4;
	localparam int CSM_PS_POWERED     = 3;
	localparam int CSM_PS_DET2        = 2;
	localparam int CSM_PS_DET1        = 1;
	localparam int CSM_PS_STATUS_LINE = 0;

	localparam logic [3:0] CSM_VOLT_RESET  = 4'h0;
	localparam logic [1:0] CSM_DET_RESET   = 2'b11;
	localparam logic       CSM_FLAG_RESET  = 1'b0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic detect_line_two_level;
		logic detect_line_one_level;
		logic status_line_level;
		logic card_irq_line_level;
	} csm_pins_s;

	localparam int CSM_PINS_W = $bits(csm_pins_s);

	typedef struct packed {
		logic [3:0] volt;
		logic       unrecognized_card;
		logic       thirtytwo_bit_card_present;
		logic       sixteen_bit_card_present;
	} csm_card_id_s;

endpackage : csm_pkg

/* csm_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module csm_sync #(
	parameter int           W         = 4,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q   <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : csm_sync
`default_nettype wire

/* csm_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module csm_monitor
	import csm_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire csm_pins_s   pins,
	input wire logic        identify_busy,
	input wire logic        socket_power_on,
	input wire logic        invalid_supply_request,
	input wire logic        socket_3v3_disable,
	input wire logic        status_change_interrupt
);
	// ==========================================================
	// Helper state
	logic [6:0] watch;
	logic [6:0] prev_q;
	logic [2:0] quiet_q;
	logic [3:0] mask_q;

	assign watch = {pins, socket_power_on, invalid_supply_request, socket_3v3_disable};

	// Counts cycles with steady card inputs and no interrogation running
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_q  <= '0;
			quiet_q <= '0;
		end else begin
			prev_q <= watch;
			if (watch != prev_q || identify_busy)
				quiet_q <= '0;
			else if (quiet_q != 3'd7)
				quiet_q <= quiet_q + 3'd1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			mask_q <= CSM_MASK_RESET;
		else if (reg_wr && reg_addr == CSM_OFS_MASK)
			mask_q <= reg_wdata[3:0];
	end

	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence present_rd;
		reg_rd && reg_addr == CSM_OFS_PRESENT;
	endsequence
	sequence settled_rd;
		present_rd ##0 quiet_q >= 3'd4;
	endsequence

	fixed_socket_bits_a: assert property (
		present_rd |=> reg_rdata[31:30] == 2'b00 && reg_rdata[28]) else $error("socket bits wrong");
	present_reserved_a: assert property (
		present_rd |=> reg_rdata[27:14] == '0) else $error("present reserved not zero");
	mask_readback_a: assert property (
		reg_rd && reg_addr == CSM_OFS_MASK |=> reg_rdata == {28'h000_0000, $past(mask_q)})
		else $error("mask readback wrong");
	socket_3v3_a: assert property (
		settled_rd |=> reg_rdata[29] == !prev_q[0]) else $error("3v3 capability wrong");
	line_levels_a: assert property (
		settled_rd |=> reg_rdata[6] == prev_q[3] && reg_rdata[0] == prev_q[4])
		else $error("card line levels wrong");
	detect_levels_a: assert property (
		settled_rd |=> reg_rdata[2:1] == prev_q[6:5]) else $error("detect levels wrong");
	power_supply_a: assert property (
		settled_rd |=> reg_rdata[3] == prev_q[2] && (reg_rdata[9] || !prev_q[1]))
		else $error("power or supply flag wrong");
	irq_gate_a: assert property (
		status_change_interrupt |-> $past(mask_q) != 4'h0 || $past(mask_q, 2) != 4'h0)
		else $error("interrupt with all enables off");
endmodule : csm_monitor

bind csm_socket csm_monitor csm_monitor_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.pins(pins), .identify_busy(identify_busy), .socket_power_on(socket_power_on),
	.invalid_supply_request(invalid_supply_request), .socket_3v3_disable(socket_3v3_disable),
	.status_change_interrupt(status_change_interrupt));
`default_nettype wire

/* csm_card_model.sv */
`timescale 1ns/10ps
`default_nettype none
module csm_card_model
	import csm_pkg::*;
(
	input  wire logic [1:0] seated,
	input  wire logic       status_drive,
	input  wire logic       ready_drive,
	output csm_pins_s       pins
);
	// Detect contacts pulled high, card lines pulled low while not fully seated
	assign pins.detect_line_two_level = !seated[1];
	assign pins.detect_line_one_level = !seated[0];
	assign pins.status_line_level     = &seated & status_drive;
	assign pins.card_irq_line_level   = &seated & ready_drive;
endmodule : csm_card_model
`default_nettype wire

/* tb_cardbus_socket_mask_and_state.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_cardbus_socket_mask_and_state
	import csm_pkg::*;
;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d;} csm_row_s;
	logic         clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, busy = 0, done = 0;
	logic         pwr = 0, invalid = 0, loss = 0, dis = 0, cst = 0, rdy = 0;
	logic         reg_rvalid, irq;
	logic [1:0]   seat = 2'b00;
	logic [7:0]   reg_addr = 8'h00;
	logic [31:0]  reg_wdata = 32'h0000_0000, reg_rdata;
	csm_card_id_s result = '0;
	csm_pins_s    pins;
	int           n_errors = 0, samples_checked = 0;
	csm_row_s     rows [9] = '{'{1'b0, 8'h04, 32'h0000_0000}, '{1'b0, 8'h08, 32'h3000_0006},
		'{1'b1, 8'h04, 32'hFFFF_FFFA}, '{1'b0, 8'h04, 32'h0000_000A},
		'{1'b1, 8'h08, 32'hFFFF_FFFF}, '{1'b0, 8'h08, 32'h3000_0006},
		'{1'b0, 8'h10, 32'h0000_0000}, '{1'b0, 8'h00, 32'h0000_0000},
		'{1'b1, 8'h04, 32'h0000_0000}};

	always #20 clk = ~clk;

	csm_card_model csm_card_model_inst (.seated(seat), .status_drive(cst), .ready_drive(rdy),
		.pins(pins));
	csm_socket csm_socket_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pins(pins), .identify_busy(busy), .identify_done(done), .identify_result(result),
		.socket_power_on(pwr), .invalid_supply_request(invalid), .removal_data_loss(loss),
		.socket_3v3_disable(dis), .status_change_interrupt(irq));

	// ==========================================================
	// Register port tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		cyc(1);
		reg_wr = 0;
	endtask : wr
	task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		cyc(1);
		reg_addr = a;
		reg_rd = 1;
		cyc(1);
		reg_rd = 0;
		`CHK("rvalid", 1'b1, reg_rvalid)
		`CHK(nm, e, reg_rdata)
	endtask : chk
	task automatic ident(input csm_card_id_s r);
		result = r;
		done = 1;
		cyc(1);
		done = 0;
		cyc(6);
	endtask : ident
	task automatic test_done;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// ==========================================================
	// Sequence
	initial begin
		repeat (3) @(posedge clk);
		#1;
		`CHK("irq", 1'b0, irq)
		rstn = 1;
		cyc(4);
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			else
				chk("row", rows[i].a, rows[i].d);
		end
		for (int i = 0; i < 4; i++) begin
			wr(CSM_OFS_FORCE, 32'(1 << i));
			chk("event", CSM_OFS_EVENT, 32'(1 << i));
			`CHK("irq", 1'b0, irq)
			wr(CSM_OFS_EVENT, 32'h0000_0000);
			chk("event", CSM_OFS_EVENT, 32'(1 << i));
			wr(CSM_OFS_MASK, (i == 1 || i == 2) ? 32'h0000_0006 : 32'(1 << i));
			cyc(2);
			`CHK("irq", 1'b1, irq)
			wr(CSM_OFS_EVENT, 32'(1 << i));
			cyc(2);
			`CHK("irq", 1'b0, irq)
			wr(CSM_OFS_MASK, 32'h0000_0000);
		end
		pwr = 1;
		busy = 1;
		seat = 2'b11;
		cyc(8);
		chk("present", CSM_OFS_PRESENT, 32'h3000_000E);
		busy = 0;
		ident({4'h3, 3'b010});
		chk("present", CSM_OFS_PRESENT, 32'h3000_0C28);
		result = {4'hF, 3'b001};
		cyc(4);
		chk("present", CSM_OFS_PRESENT, 32'h3000_0C28);
		ident({4'h0, 3'b100});
		chk("present", CSM_OFS_PRESENT, 32'h3000_0CA8);
		ident({4'h1, 3'b001});
		chk("present", CSM_OFS_PRESENT, 32'h3000_0418);
		wr(CSM_OFS_EVENT, 32'h0000_000F);
		cst = 1;
		rdy = 1;
		cyc(8);
		chk("present", CSM_OFS_PRESENT, 32'h3000_0459);
		chk("event", CSM_OFS_EVENT, 32'h0000_0001);
		wr(CSM_OFS_EVENT, 32'h0000_0001);
		cst = 0;
		cyc(8);
		chk("event", CSM_OFS_EVENT, 32'h0000_0001);
		wr(CSM_OFS_FORCE, 32'h0000_0020);
		wr(CSM_OFS_EVENT, 32'h0000_0001);
		chk("present", CSM_OFS_PRESENT, 32'h3000_0068);
		cst = 1;
		cyc(8);
		chk("event", CSM_OFS_EVENT, 32'h0000_0001);
		wr(CSM_OFS_EVENT, 32'h0000_0001);
		cst = 0;
		cyc(8);
		chk("event", CSM_OFS_EVENT, 32'h0000_0000);
		wr(CSM_OFS_FORCE, 32'h0000_3FB0);
		chk("present", CSM_OFS_PRESENT, 32'h3000_3FF8);
		wr(CSM_OFS_FORCE, 32'h0000_0000);
		invalid = 1;
		dis = 1;
		pwr = 0;
		loss = 1;
		cyc(1);
		loss = 0;
		cyc(8);
		chk("present", CSM_OFS_PRESENT, 32'h1000_0340);
		wr(CSM_OFS_MASK, 32'h0000_000F);
		cyc(2);
		`CHK("irq", 1'b1, irq)
		rstn = 0;
		cyc(2);
		`CHK("irq", 1'b0, irq)
		rstn = 1;
		cyc(4);
		chk("mask", CSM_OFS_MASK, 32'h0000_0000);
		chk("event", CSM_OFS_EVENT, 32'h0000_0006);
		`CHK("irq", 1'b0, irq)
		chk("present", CSM_OFS_PRESENT, 32'h1000_0240);
		test_done();
	end

	initial begin
		#120000;
		n_errors++;
		test_done();
	end
endmodule : tb_cardbus_socket_mask_and_state
`default_nettype wire
